/* File: design/tohz_map.svh */
`ifndef TOHZ_MAP_SVH
`define TOHZ_MAP_SVH
// Register offsets (byte addresses)
`define TOHZ_OFS_STOP_TRIG 20'hf0226
`define TOHZ_OFS_EDGE_CTRL 20'hf0228
`define TOHZ_OFS_STATUS 20'hf022a
`define TOHZ_OFS_START_TRIG 20'hf022c
`define TOHZ_OFS_MODE 20'hf022e
`define TOHZ_OFS_RT_ENABLE 20'hf0230
`define TOHZ_OFS_RT_LEVEL 20'hf0232
`define TOHZ_OFS_RT_TRIGSEL 20'hf0234
// Field positions
`define TOHZ_BIT_MODE 0
`define TOHZ_BIT_SRC 1
`define TOHZ_BIT_HSM 2
`define TOHZ_BIT_HDM 3
`define TOHZ_ST_ACT1 15
`define TOHZ_ST_ACT0 14
`define TOHZ_ST_IN1 1
`define TOHZ_ST_IN0 0
// Reset values
`define TOHZ_RST_16 16'h0000
`define TOHZ_RST_2 2'h0
// Real-time trigger channel range
`define TOHZ_TRIG_LO 1
`define TOHZ_TRIG_HI 10
`endif

/* File: design/tohz_pkg.sv */
package tohz_pkg;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tohz_bus_req_t;
  typedef struct packed {
    logic pin;
    logic cmp;
  } tohz_src_t;
  typedef enum logic [1:0] {
    TOHZ_IDLE = 2'b00,
    TOHZ_FLOAT = 2'b01,
    TOHZ_CANCEL = 2'b10
  } tohz_state_t;
endpackage : tohz_pkg

/* File: design/tohz_hiz_ctrl.sv */
`timescale 1ns/1ns
`include "tohz_map.svh"
// One high-impedance control signal: set on event, cleared at a PWM boundary
module tohz_hiz_ctrl
  import tohz_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Requests
  input wire logic set_req,
  input wire logic cancel_req,
  input wire logic pwm_boundary,
  // State
  output logic active
);
  tohz_state_t state_q;

  // ----------------------------------------
  // Hold floating until a cancel lands on a PWM boundary
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= TOHZ_IDLE;
    end else begin
      case (state_q)
        TOHZ_IDLE: begin
          if (set_req) begin
            state_q <= TOHZ_FLOAT;
          end
        end
        TOHZ_FLOAT: begin
          if (cancel_req && !set_req) begin
            state_q <= TOHZ_CANCEL;
          end
        end
        TOHZ_CANCEL: begin
          // A new event re-arms the float; set wins over the PWM boundary
          if (set_req) begin
            state_q <= TOHZ_FLOAT;
          end else if (pwm_boundary) begin
            state_q <= TOHZ_IDLE;
          end
        end
        default: begin
          state_q <= TOHZ_IDLE;
        end
      endcase
    end
  end

  assign active = (state_q != TOHZ_IDLE);
endmodule : tohz_hiz_ctrl

/* File: design/tohz_rt_output.sv */
`timescale 1ns/1ns
`include "tohz_map.svh"
// Real-time output routing across the channel array
module tohz_rt_output
  import tohz_pkg::*;
#(
  parameter int NCH = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [NCH-1:0] rt_output_enable,
  input wire logic [NCH-1:0] rt_output_level,
  input wire logic [NCH-1:0] rt_trigger_select,
  input wire logic [NCH-1:0] channel_interval_irq,
  // Result
  output logic [NCH-1:0] rt_pin_q,
  output logic [NCH-1:0] rt_governed_q
);
  logic [NCH-1:0] trig_ok;
  logic [NCH-1:0] gov_fire;
  logic [NCH-1:0] gov_valid;

  // ----------------------------------------
  // Governing trigger channel search
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Only channels in the legal range may generate triggers
      assign trig_ok[g] = rt_trigger_select[g] && (g >= `TOHZ_TRIG_LO) &&
                          (g <= `TOHZ_TRIG_HI);
      if (g == 0) begin : g_top
        // Nothing sits above channel 0
        assign gov_valid[g] = trig_ok[g];
        assign gov_fire[g] = trig_ok[g] && channel_interval_irq[g];
      end else begin : g_low
        // Inherit from the next higher channel while select is 0
        assign gov_valid[g] = trig_ok[g] ? 1'b1 : gov_valid[g-1];
        assign gov_fire[g] = trig_ok[g] ? channel_interval_irq[g] :
                             gov_fire[g-1];
      end
    end
  endgenerate

  // ----------------------------------------
  // Pin update only on the governing interrupt
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rt_pin_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (rt_output_enable[i] && gov_valid[i] && gov_fire[i]) begin
          rt_pin_q[i] <= rt_output_level[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rt_governed_q <= '0;
    end else begin
      rt_governed_q <= rt_output_enable & gov_valid;
    end
  end
endmodule : tohz_rt_output

/* File: design/tohz_top.sv */
// What this block does
// - Active status bits show control signal level
// - Input status 1 mirrors pin or comparator
// - Input status 0 mirrors pin or comparator
// - Mode picks which channels each signal floats
// - Start trigger floats outputs, self-clears
// - Start register reads zero, two bits
// - Stop trigger requests cancel, self-clears
// - Stop register reads zero, two bits
// - Stop 1 cancels 6,7 if input 1 low
// - Stop 1 needs half-bridge and software cancel
// - Stop 0 six-phase cancels 2-7 if input1 low
// - Stop 0 half-bridge cancels 2,3 if input0 low
// - Stop 0 acts only in listed combinations
// - Edge enable 1 gates source 1 edges
// - Edge enable 0 gates source 0 edges
// - Edge control resets zero, two bits
// - Enabled channel pin takes level on trigger
// - Level reaches pin only on governing interrupt
// - Select bit makes trigger channel, 1 to 10
// - Trigger governs lower channels until next trigger
// - Trigger role independent of own enable
// - No governing trigger means no real-time output
// - Mode bit: six-phase or half-bridge
// - Source select: pins or comparators
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "tohz_map.svh"
module tohz_top
  import tohz_pkg::*;
#(
  parameter int NCH = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [19:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Shutdown sources
  input wire logic shutdown_pin_0,
  input wire logic shutdown_pin_1,
  input wire logic comparator_out_0,
  input wire logic comparator_out_1,
  // PWM period boundary pulse
  input wire logic pwm_cycle_end,
  // Timer channel side
  input wire logic [NCH-1:0] channel_interval_irq,
  input wire logic [NCH-1:0] timer_output,
  // Pins
  output logic [NCH-1:0] channel_output_pin,
  output logic [NCH-1:0] channel_output_oe
);
  tohz_bus_req_t req;
  tohz_src_t src0;
  tohz_src_t src1;
  logic [1:0] edge_ctrl_q;
  logic [1:0] start_q;
  logic [1:0] stop_q;
  logic [3:0] mode_q;
  logic [NCH-1:0] rt_en_q;
  logic [NCH-1:0] rt_lvl_q;
  logic [NCH-1:0] rt_sel_q;
  logic [NCH-1:0] rt_pin;
  logic [NCH-1:0] rt_gov;
  logic in0_q;
  logic in1_q;
  logic lvl0_d;
  logic lvl1_d;
  logic act0;
  logic act1;
  logic set0;
  logic set1;
  logic cancel0;
  logic cancel1;
  logic edge_cancel0;
  logic edge_cancel1;
  logic bridge_mode_sel;
  logic shutdown_source_sel;
  logic halfbridge_cancel_method;
  logic sixphase_cancel_method;
  logic [NCH-1:0] float_mask;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign src0 = '{pin: shutdown_pin_0, cmp: comparator_out_0};
  assign src1 = '{pin: shutdown_pin_1, cmp: comparator_out_1};

  function automatic logic wr_hit(input tohz_bus_req_t r, input logic [19:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction : wr_hit

  assign bridge_mode_sel = mode_q[`TOHZ_BIT_MODE];
  assign shutdown_source_sel = mode_q[`TOHZ_BIT_SRC];
  assign halfbridge_cancel_method = mode_q[`TOHZ_BIT_HSM];
  assign sixphase_cancel_method = mode_q[`TOHZ_BIT_HDM];

  // ----------------------------------------
  // Source selection and input status
  // ----------------------------------------
  assign lvl0_d = shutdown_source_sel ? src0.cmp : src0.pin;
  assign lvl1_d = shutdown_source_sel ? src1.cmp : src1.pin;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in0_q <= 1'b0;
      in1_q <= 1'b0;
    end else begin
      in0_q <= lvl0_d;
      in1_q <= lvl1_d;
    end
  end

  // A rising edge on an enabled source is the shutdown event; disabled edges are ignored
  assign edge_cancel0 = edge_ctrl_q[0] && in0_q && !lvl0_d;
  assign edge_cancel1 = edge_ctrl_q[1] && in1_q && !lvl1_d;
  assign set0 = (edge_ctrl_q[0] && lvl0_d && !in0_q) || start_q[0];
  assign set1 = (edge_ctrl_q[1] && lvl1_d && !in1_q) || start_q[1];

  // ----------------------------------------
  // Cancellation decisions
  // ----------------------------------------
  always_comb begin
    cancel0 = 1'b0;
    cancel1 = 1'b0;
    if (stop_q[0]) begin
      if (!bridge_mode_sel && !sixphase_cancel_method) begin
        cancel0 = !in1_q;
      end else if (bridge_mode_sel && halfbridge_cancel_method) begin
        cancel0 = !in0_q;
      end
    end
    if (stop_q[1] && bridge_mode_sel && halfbridge_cancel_method) begin
      cancel1 = !in1_q;
    end
    // Hardware cancel after inactive edge in the other methods; for signal 0 in six-phase mode under either method
    if (edge_cancel0 && (bridge_mode_sel ? !halfbridge_cancel_method : 1'b1)) begin
      cancel0 = 1'b1;
    end
    if (edge_cancel1 && bridge_mode_sel && !halfbridge_cancel_method) begin
      cancel1 = 1'b1;
    end
  end

  tohz_hiz_ctrl u_ctrl0 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_req(set0),
    .cancel_req(cancel0),
    .pwm_boundary(pwm_cycle_end),
    .active(act0)
  );

  tohz_hiz_ctrl u_ctrl1 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_req(set1 && bridge_mode_sel),
    .cancel_req(cancel1),
    .pwm_boundary(pwm_cycle_end),
    .active(act1)
  );

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      edge_ctrl_q <= `TOHZ_RST_2;
    end else if (wr_hit(req, `TOHZ_OFS_EDGE_CTRL)) begin
      edge_ctrl_q <= req.wdata[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_q <= '0;
    end else if (wr_hit(req, `TOHZ_OFS_MODE)) begin
      mode_q <= req.wdata[3:0];
    end
  end

  // Trigger bits: a write sets, completion clears; a new write wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_q <= `TOHZ_RST_2;
    end else if (wr_hit(req, `TOHZ_OFS_START_TRIG)) begin
      start_q <= start_q | req.wdata[1:0];
    end else begin
      // Trigger 1 has no target outside half-bridge mode; dropping it keeps
      // a stale request from floating outputs after a later mode change
      start_q <= start_q & ~{act1 | !bridge_mode_sel, act0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stop_q <= `TOHZ_RST_2;
    end else if (wr_hit(req, `TOHZ_OFS_STOP_TRIG)) begin
      stop_q <= req.wdata[1:0];
    end else begin
      // Request is issued in the cycle the bit is seen, then cleared
      stop_q <= `TOHZ_RST_2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rt_en_q <= '0;
      rt_lvl_q <= '0;
      rt_sel_q <= '0;
    end else begin
      if (wr_hit(req, `TOHZ_OFS_RT_ENABLE)) begin
        rt_en_q <= req.wdata[NCH-1:0];
      end
      if (wr_hit(req, `TOHZ_OFS_RT_LEVEL)) begin
        rt_lvl_q <= req.wdata[NCH-1:0];
      end
      if (wr_hit(req, `TOHZ_OFS_RT_TRIGSEL)) begin
        rt_sel_q <= req.wdata[NCH-1:0];
      end
    end
  end

  // ----------------------------------------
  // Register reads; trigger registers read zero
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= `TOHZ_RST_16;
    end else if (req.rd) begin
      case (req.addr)
        `TOHZ_OFS_STATUS: begin
          reg_rdata <= `TOHZ_RST_16;
          reg_rdata[`TOHZ_ST_ACT1] <= act1;
          reg_rdata[`TOHZ_ST_ACT0] <= act0;
          reg_rdata[`TOHZ_ST_IN1] <= in1_q;
          reg_rdata[`TOHZ_ST_IN0] <= in0_q;
        end
        `TOHZ_OFS_EDGE_CTRL: reg_rdata <= {14'h0000, edge_ctrl_q};
        `TOHZ_OFS_MODE: reg_rdata <= {12'h000, mode_q};
        `TOHZ_OFS_RT_ENABLE: reg_rdata <= 16'(rt_en_q);
        `TOHZ_OFS_RT_LEVEL: reg_rdata <= 16'(rt_lvl_q);
        `TOHZ_OFS_RT_TRIGSEL: reg_rdata <= 16'(rt_sel_q);
        default: reg_rdata <= `TOHZ_RST_16;
      endcase
    end else begin
      reg_rdata <= `TOHZ_RST_16;
    end
  end

  // ----------------------------------------
  // Real-time output
  // ----------------------------------------
  tohz_rt_output #(.NCH(NCH)) u_rt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rt_output_enable(rt_en_q),
    .rt_output_level(rt_lvl_q),
    .rt_trigger_select(rt_sel_q),
    .channel_interval_irq(channel_interval_irq),
    .rt_pin_q(rt_pin),
    .rt_governed_q(rt_gov)
  );

  // ----------------------------------------
  // Float mask per mode
  // ----------------------------------------
  always_comb begin
    float_mask = '0;
    if (!bridge_mode_sel) begin
      float_mask[7:2] = {6{act0}};
    end else begin
      float_mask[3:2] = {2{act0}};
      float_mask[7:6] = {2{act1}};
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      channel_output_pin <= '0;
    end else begin
      channel_output_pin <= (rt_gov & rt_pin) | (~rt_gov & timer_output);
    end
  end

  // Enables stay low through reset so no channel drives before it is set up
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      channel_output_oe <= '0;
    end else begin
      channel_output_oe <= ~float_mask;
    end
  end
endmodule : tohz_top

/* File: tb/tohz_top_sva.sv */
`timescale 1ns/1ns
`include "tohz_map.svh"
module tohz_top_chk
  import tohz_pkg::*;
#(
  parameter int NCH = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [19:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Shutdown sources and boundary
  input wire logic shutdown_pin_0,
  input wire logic shutdown_pin_1,
  input wire logic comparator_out_0,
  input wire logic comparator_out_1,
  input wire logic pwm_cycle_end,
  // Channel side
  input wire logic [NCH-1:0] timer_output,
  input wire logic [NCH-1:0] channel_output_pin,
  input wire logic [NCH-1:0] channel_output_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Quiet sources, held long enough to cover the status sampling lag
  wire q0 = !shutdown_pin_0 && !comparator_out_0;
  wire q1 = !shutdown_pin_1 && !comparator_out_1;
  start_reads_zero_a: assert property (
    $past(reg_rd && reg_addr == `TOHZ_OFS_START_TRIG) |-> reg_rdata == 16'h0000)
    else $error("start trigger read not zero");
  stop_reads_zero_a: assert property (
    $past(reg_rd && reg_addr == `TOHZ_OFS_STOP_TRIG) |-> reg_rdata == 16'h0000)
    else $error("stop trigger read not zero");
  edge_ctrl_bits_a: assert property (
    $past(reg_rd && reg_addr == `TOHZ_OFS_EDGE_CTRL) |-> reg_rdata[15:2] == 14'h0000)
    else $error("edge control upper bits set");
  input0_quiet_a: assert property (
    $past(reg_rd && reg_addr == `TOHZ_OFS_STATUS) && $past(q0) && $past(q0, 2)
    && $past(q0, 3) |-> !reg_rdata[0]) else $error("input status 0 wrong");
  input1_quiet_a: assert property (
    $past(reg_rd && reg_addr == `TOHZ_OFS_STATUS) && $past(q1) && $past(q1, 2)
    && $past(q1, 3) |-> !reg_rdata[1]) else $error("input status 1 wrong");
  outer_driven_a: assert property (
    $past(rst_n) |-> channel_output_oe[1:0] == 2'b11 && (&channel_output_oe[NCH-1:8]))
    else $error("uncontrolled channel floated");
  pairs_equal_a: assert property (
    channel_output_oe[3] == channel_output_oe[2] && channel_output_oe[5] == channel_output_oe[4]
    && channel_output_oe[7] == channel_output_oe[6]) else $error("channel pair split");
  middle_group_a: assert property (
    !channel_output_oe[4] |-> channel_output_oe[7:2] == 6'h00)
    else $error("six-phase group split");
  release_boundary_a: assert property (
    $past(rst_n, 2) && ($rose(channel_output_oe[2]) || $rose(channel_output_oe[6]))
    |-> $past(pwm_cycle_end, 2)) else $error("float released off boundary");
  ch0_timer_a: assert property (
    $past(rst_n) |-> channel_output_pin[0] == $past(timer_output[0]))
    else $error("channel 0 not timer level");
  cover property ($fell(channel_output_oe[4]));
  cover property ($fell(channel_output_oe[6]) && channel_output_oe[2]);
  cover property ($rose(channel_output_oe[6]));
endmodule : tohz_top_chk

bind tohz_top tohz_top_chk #(.NCH(NCH)) chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .shutdown_pin_0(shutdown_pin_0), .shutdown_pin_1(shutdown_pin_1),
  .comparator_out_0(comparator_out_0), .comparator_out_1(comparator_out_1),
  .pwm_cycle_end(pwm_cycle_end), .timer_output(timer_output),
  .channel_output_pin(channel_output_pin), .channel_output_oe(channel_output_oe));

/* File: tb/tohz_power_stage.sv */
`timescale 1ns/1ns
module tohz_power_stage (
  // Clock
  input wire logic ref_clk,
  // Fault requests
  input wire logic [1:0] fault_req,
  input wire logic use_cmp,
  // Shutdown sources
  output logic shutdown_pin_0,
  output logic shutdown_pin_1,
  output logic comparator_out_0,
  output logic comparator_out_1
);
  // A fault shows on one source only, so a wrong source select is seen
  initial {shutdown_pin_0, shutdown_pin_1, comparator_out_0, comparator_out_1} = 4'h0;
  always @(posedge ref_clk) begin
    shutdown_pin_0 <= fault_req[0] & ~use_cmp;
    shutdown_pin_1 <= fault_req[1] & ~use_cmp;
    comparator_out_0 <= fault_req[0] & use_cmp;
    comparator_out_1 <= fault_req[1] & use_cmp;
  end
endmodule : tohz_power_stage

/* File: tb/test_tohz_top.sv */
`timescale 1ns/1ns
`include "tohz_map.svh"
module test_tohz_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [19:0] reg_addr = 20'h00000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [1:0] fault_req = 2'h0;
  logic use_cmp = 1'b0;
  logic sp0, sp1, cp0, cp1;
  logic pwm_cycle_end = 1'b0;
  logic [11:0] irq = 12'h000;
  logic [11:0] timer_output = 12'h000;
  logic [11:0] pin, oe, lvl, rtv;
  logic [15:0] exp_q[$];
  logic rd_d = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 24206;

  initial forever #5 ref_clk = ~ref_clk;

  tohz_power_stage stage_u (.ref_clk(ref_clk), .fault_req(fault_req), .use_cmp(use_cmp),
    .shutdown_pin_0(sp0), .shutdown_pin_1(sp1), .comparator_out_0(cp0),
    .comparator_out_1(cp1));
  tohz_top #(.NCH(12)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .shutdown_pin_0(sp0), .shutdown_pin_1(sp1), .comparator_out_0(cp0),
    .comparator_out_1(cp1), .pwm_cycle_end(pwm_cycle_end), .channel_interval_irq(irq),
    .timer_output(timer_output), .channel_output_pin(pin), .channel_output_oe(oe));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // Extra edges let a stop request reach its cancel state first
  task automatic pwm();
    cyc(3);
    pwm_cycle_end <= 1'b1;
    @(posedge ref_clk);
    pwm_cycle_end <= 1'b0;
  endtask : pwm

  task automatic wait_oe(input logic [11:0] e);
    int i;
    for (i = 0; i < 10 && oe !== e; i++) @(posedge ref_clk);
    // A bound that runs out is counted by the compare itself
    check({4'h0, oe}, {4'h0, e});
    if (oe !== e) give_verdict();
  endtask : wait_oe

  task automatic irq_pin(input logic [11:0] m);
    @(posedge ref_clk);
    irq <= m;
    @(posedge ref_clk);
    irq <= 12'h000;
    cyc(3);
    check({4'h0, pin}, {4'h0, (12'hf5c & rtv) | (~12'hf5c & timer_output)});
  endtask : irq_pin

  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d) check(reg_rdata, exp_q.pop_front());
  end

  initial begin
    cyc(16);
    rst_n <= 1'b1;
    wait_oe(12'hfff);
    rd(`TOHZ_OFS_EDGE_CTRL, 16'h0000);
    wr(`TOHZ_OFS_EDGE_CTRL, 16'hffff);
    rd(`TOHZ_OFS_EDGE_CTRL, 16'h0003);
    wr(`TOHZ_OFS_EDGE_CTRL, 16'h0000);
    rd(20'hf0300, 16'h0000);
    // ---------------------------------------------------------------
    // Six-phase software float and cancel
    // ---------------------------------------------------------------
    wr(`TOHZ_OFS_START_TRIG, 16'h0001);
    wait_oe(12'hf03);
    rd(`TOHZ_OFS_START_TRIG, 16'h0000);
    fault_req <= 2'b10;
    cyc(3);
    rd(`TOHZ_OFS_STATUS, 16'h4002);
    wr(`TOHZ_OFS_STOP_TRIG, 16'h0001);
    rd(`TOHZ_OFS_STOP_TRIG, 16'h0000);
    pwm();
    cyc(3);
    check({4'h0, oe}, 16'h0f03);
    fault_req <= 2'b00;
    wr(`TOHZ_OFS_STOP_TRIG, 16'h0001);
    cyc(4);
    check({4'h0, oe}, 16'h0f03);
    pwm();
    wait_oe(12'hfff);
    // ---------------------------------------------------------------
    // Half-bridge, pins then comparators
    // ---------------------------------------------------------------
    for (int s = 0; s < 2; s++) begin
      wr(`TOHZ_OFS_EDGE_CTRL, 16'h0000);
      use_cmp <= s[0];
      wr(`TOHZ_OFS_MODE, 16'h0005 | 16'(s << 1));
      fault_req <= 2'b10;
      cyc(4);
      check({4'h0, oe}, 16'h0fff);
      fault_req <= 2'b00;
      wr(`TOHZ_OFS_EDGE_CTRL, 16'h0003);
      fault_req <= 2'b10;
      wait_oe(12'hf3f);
      rd(`TOHZ_OFS_STATUS, 16'h8002);
      wr(`TOHZ_OFS_STOP_TRIG, 16'h0002);
      pwm();
      cyc(3);
      check({4'h0, oe}, 16'h0f3f);
      fault_req <= 2'b01;
      wait_oe(12'hf33);
      rd(`TOHZ_OFS_STATUS, 16'hc001);
      wr(`TOHZ_OFS_STOP_TRIG, 16'h0003);
      pwm();
      cyc(3);
      check({4'h0, oe}, 16'h0ff3);
      fault_req <= 2'b00;
      wr(`TOHZ_OFS_STOP_TRIG, 16'h0001);
      pwm();
      wait_oe(12'hfff);
    end
    // ---------------------------------------------------------------
    // Half-bridge, hardware cancel: stop 1 ignored, falling edge frees
    // ---------------------------------------------------------------
    wr(`TOHZ_OFS_MODE, 16'h0003);
    fault_req <= 2'b10;
    wait_oe(12'hf3f);
    wr(`TOHZ_OFS_STOP_TRIG, 16'h0002);
    pwm();
    cyc(3);
    check({4'h0, oe}, 16'h0f3f);
    fault_req <= 2'b00;
    pwm();
    wait_oe(12'hfff);
    // ---------------------------------------------------------------
    // Real-time output: triggers on 2 and 5, 11 selected but ignored
    // ---------------------------------------------------------------
    wr(`TOHZ_OFS_EDGE_CTRL, 16'h0000);
    wr(`TOHZ_OFS_MODE, 16'h0000);
    rtv = 12'h000;
    lvl = 12'($random(seed));
    timer_output <= 12'($random(seed));
    wr(`TOHZ_OFS_RT_TRIGSEL, 16'h0824);
    wr(`TOHZ_OFS_RT_ENABLE, 16'h0f5f);
    wr(`TOHZ_OFS_RT_LEVEL, {4'h0, lvl});
    irq_pin(12'h808);
    rtv[11:5] = lvl[11:5];
    irq_pin(12'h020);
    irq_pin(12'h000);
    lvl = 12'($random(seed));
    wr(`TOHZ_OFS_RT_LEVEL, {4'h0, lvl});
    irq_pin(12'h010);
    rtv[4:2] = lvl[4:2];
    irq_pin(12'h004);
    irq_pin(12'h000);
    cyc(3);
    give_verdict();
  end
endmodule : test_tohz_top
